/* File: rtl/read_decoder_pkg.sv */
// constants and decode tables for the register-read command decoder
package read_decoder_pkg;

  // command space of the read codes
  localparam logic [15:0] READ_CODE_FIRST = 16'h00C0;
  localparam logic [15:0] READ_CODE_LAST = 16'h00FF;
  localparam int IMAGE_DEPTH = 64;
  localparam int INDEX_WIDTH = 6;
  localparam int DATA_WIDTH = 32;
  localparam int WORD_WIDTH = 16;
  localparam logic [DATA_WIDTH-1:0] IMAGE_RESET_VALUE = 32'h0000_0000;
  localparam logic [5:0] FULL_WIDTH = 6'h20;

  // effective width of each item, indexed by the low six bits of the read code
  function automatic logic [5:0] effWidth(input logic [5:0] idx);
    logic [5:0] w;
    w = 6'h00;
    case (idx)
      6'h00, 6'h08, 6'h0B, 6'h0D, 6'h0E: w = 6'h1C;
      6'h01, 6'h02: w = 6'h11;
      6'h03, 6'h04, 6'h09, 6'h0A: w = 6'h10;
      6'h05: w = 6'h20;
      6'h06, 6'h0F: w = 6'h18;
      6'h07, 6'h0C: w = 6'h1F;
      6'h10, 6'h18, 6'h23, 6'h24, 6'h27, 6'h28, 6'h29, 6'h2B: w = 6'h1C;
      6'h2D, 6'h2E, 6'h34, 6'h3D, 6'h3E: w = 6'h1C;
      6'h11, 6'h12, 6'h1B, 6'h2C, 6'h2F, 6'h33: w = 6'h11;
      6'h13, 6'h14, 6'h19, 6'h1A, 6'h25: w = 6'h10;
      6'h15: w = 6'h0B;
      6'h16, 6'h36: w = 6'h18;
      6'h17, 6'h1E, 6'h3B, 6'h3C: w = 6'h1F;
      6'h1D: w = 6'h1D;
      6'h32: w = 6'h17;
      6'h35: w = 6'h1B;
      6'h1C, 6'h1F, 6'h20, 6'h21, 6'h31, 6'h37, 6'h38, 6'h39, 6'h3A, 6'h3F: w = 6'h20;
      default: w = 6'h00;
    endcase
    return w;
  endfunction : effWidth

  // items whose top effective bit is copied into the unused high bits
  function automatic logic signExtended(input logic [5:0] idx);
    logic s;
    s = 1'b0;
    case (idx)
      6'h00, 6'h06, 6'h08, 6'h0B, 6'h0D, 6'h0E, 6'h10, 6'h16, 6'h18: s = 1'b1;
      6'h23, 6'h24, 6'h25, 6'h27, 6'h28, 6'h29, 6'h2D, 6'h2E: s = 1'b1;
      6'h34, 6'h3D, 6'h3E: s = 1'b1;
      default: s = 1'b0;
    endcase
    return s;
  endfunction : signExtended

endpackage : read_decoder_pkg

/* File: rtl/reg_image_if.sv */
// carrier between the decoder and its register image store
`timescale 1ns/1ps
interface reg_image_if;
  logic wrEn;
  logic [read_decoder_pkg::INDEX_WIDTH-1:0] wrIndex;
  logic [read_decoder_pkg::DATA_WIDTH-1:0] wrData;
  logic [read_decoder_pkg::INDEX_WIDTH-1:0] rdIndex;
  logic [read_decoder_pkg::DATA_WIDTH-1:0] rdData;

  modport decoder (output wrEn, output wrIndex, output wrData, output rdIndex, input rdData);
  modport store (input wrEn, input wrIndex, input wrData, input rdIndex, output rdData);
endinterface : reg_image_if

/* File: rtl/reg_image_store.sv */
// image of all readable registers and pre-registers, registered read port
`timescale 1ns/1ps
module reg_image_store (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  reg_image_if.store img
);

  logic [read_decoder_pkg::DATA_WIDTH-1:0] mem_r [read_decoder_pkg::IMAGE_DEPTH];
  logic [read_decoder_pkg::DATA_WIDTH-1:0] rdData_r;

  // every entry clears on reset so untouched items read as zero
  genvar g;
  generate
    for (g = 0; g < read_decoder_pkg::IMAGE_DEPTH; g++)
    begin : gEntry
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          mem_r[g] <= read_decoder_pkg::IMAGE_RESET_VALUE;
        else if (ce && img.wrEn && img.wrIndex == 6'(g))
          mem_r[g] <= img.wrData;
      end
    end
  endgenerate

  // read returns the value before a same-cycle write
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdData_r <= read_decoder_pkg::IMAGE_RESET_VALUE;
    else if (ce)
      rdData_r <= mem_r[img.rdIndex];
  end

  assign img.rdData = rdData_r;

endmodule : reg_image_store

/* File: rtl/register_read_command_decoder.sv */
// decoder of one-word register read commands with three-word answers
//
// Functional notes
// - codes 00C0h..00FFh other than 00E2h, 00E6h, 00EAh and 00F0h each read exactly one register and return it.
// - answer is three words: echoed code, lower data, upper data.
// - sixteen-bit items other than 00E5h answer with whole value, then a zero word; 00E5h sign-fills the upper word.
// - 00C0h returns queued positioning amount, 28 effective bits.
// - 00C1h returns queued start speed setting, 17 bits over both words.
// - 00C6h returns queued ramp down point, 24 effective bits.
// - 00C7h returns queued operation mode setting, 31 effective bits.
// - 00CBh returns queued third comparator value, 28 effective bits.
// - 00C5h answers 32 bits; working magnification 00D5h answers 11 bits.
// - 00CCh returns queued arc step count, 31 effective bits.
// - 00CDh returns queued second axis positioning amount, 28 bits.
// - 00CEh returns queued arc center y, 28 effective bits.
// - 00C8h returns queued arc center x, 28 effective bits.
// - sign-extension bits read as copy of the top meaningful bit.
// - everything reads zero after reset until written.
//
// a command is taken at an edge with ce, cmdValid and cmdReady all high;
// codes outside the read block are consumed without any answer;
// ce low freezes every register, so an answer stretches along with it.
`timescale 1ns/1ps
module register_read_command_decoder (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  output logic cmdReady,
  input wire logic imgWrEn,
  input wire logic [5:0] imgWrIndex,
  input wire logic [31:0] imgWrData,
  output logic respValid,
  output logic [15:0] respWord,
  output logic respLast
);

  // with ce high a code taken at edge 0 is echoed after edge 1, its lower
  // half follows after edge 2 and its upper half after edge 3; the image
  // read port is registered, so the fetch phase is the cycle in which the
  // stored word and the latched code first meet the shaping logic
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_LOW = 2'b10,
    ST_HIGH = 2'b11
  } phase_e;

  phase_e state_r;
  logic cmdReady_r;
  logic respValid_r;
  logic respLast_r;
  logic [15:0] respWord_r;
  logic [15:0] code_r;
  logic [31:0] value_r;
  logic [31:0] shaped;
  logic [5:0] itemWidth;
  logic itemSigned;
  logic topBit;
  logic isRead;
  logic take;
  logic start;

  // read codes fill one contiguous block of the command space
  function automatic logic inReadRange(input logic [15:0] code);
    logic hit;
    hit = (code >= read_decoder_pkg::READ_CODE_FIRST) &&
      (code <= read_decoder_pkg::READ_CODE_LAST);
    return hit;
  endfunction : inReadRange

  // word that leaves in the cycle after each phase; idle sends zero
  function automatic logic [15:0] answerWord(input phase_e st, input logic [15:0] code,
    input logic [31:0] value);
    logic [15:0] word;
    word = 16'h0000;
    case (st)
      ST_FETCH: word = code;
      ST_LOW: word = value[15:0];
      ST_HIGH: word = value[31:16];
      default: word = 16'h0000;
    endcase
    return word;
  endfunction : answerWord

  // image store: one word per read code, registered read port
  reg_image_if img ();

  reg_image_store uStore (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .img(img)
  );

  // write side of the image is fed by the rest of the device
  // a read taken at the edge of a write still sees the older word
  assign img.wrEn = imgWrEn;
  assign img.wrIndex = imgWrIndex;
  assign img.wrData = imgWrData;
  // low six bits pick the item; the code range covers all 64 entries
  assign img.rdIndex = cmdWord[5:0];

  // only the read range is answered; other codes belong to other decoders
  assign isRead = inReadRange(cmdWord);
  assign take = ce && cmdValid && cmdReady_r;
  // a foreign code is taken off the link but starts no answer
  assign start = take && isRead;

  // width and sign class of the item being answered
  assign itemWidth = read_decoder_pkg::effWidth(code_r[5:0]);
  assign itemSigned = read_decoder_pkg::signExtended(code_r[5:0]);

  // top meaningful bit of the stored word; an item of width zero has none,
  // so codes without an item answer plain zero
  always_comb
  begin
    topBit = 1'b0;
    if (itemWidth != 6'h00)
      topBit = img.rdData[5'(itemWidth - 6'h01)];
  end

  // each bit is kept below the width and zero- or sign-filled above it;
  // what software wrote into the fill bits is never shown
  genvar b;
  generate
    for (b = 0; b < read_decoder_pkg::DATA_WIDTH; b++)
    begin : gShape
      assign shaped[b] = (itemWidth == read_decoder_pkg::FULL_WIDTH || 6'(b) < itemWidth) ?
        img.rdData[b] : (itemSigned & topBit);
    end
  endgenerate

  // one command at a time: ready drops when a read code is accepted, so answers never interleave
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cmdReady_r <= 1'b1;
    else if (ce)
    begin
      if (start)
        cmdReady_r <= 1'b0;
      else if (state_r == ST_HIGH)
        cmdReady_r <= 1'b1;
    end
  end

  // phase sequencer: fetch, then echo, lower and upper words
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_r <= ST_IDLE;
    else if (ce)
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start)
            state_r <= ST_FETCH;
        end
        ST_FETCH:
          state_r <= ST_LOW;
        ST_LOW:
          state_r <= ST_HIGH;
        ST_HIGH:
          state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // the code is kept for the echo word and for the width lookup
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      code_r <= 16'h0000;
    else if (ce && start)
      code_r <= cmdWord;
  end

  // shaped value is held while the two data words go out
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      value_r <= 32'h0000_0000;
    else if (ce && state_r == ST_FETCH)
      value_r <= shaped;
  end

  // answer framing: valid over the three words, last with the upper one
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      respValid_r <= 1'b0;
      respLast_r <= 1'b0;
    end
    else if (ce)
    begin
      respValid_r <= (state_r != ST_IDLE);
      respLast_r <= (state_r == ST_HIGH);
    end
  end

  // answer words: echo, lower half, upper half
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      respWord_r <= 16'h0000;
    else if (ce)
      respWord_r <= answerWord(state_r, code_r, value_r);
  end

  // outputs come straight from their registers
  assign cmdReady = cmdReady_r;
  assign respValid = respValid_r;
  assign respWord = respWord_r;
  assign respLast = respLast_r;

endmodule : register_read_command_decoder

/* File: bench/cmd_source.sv */
// controller model that issues queued read codes
`timescale 1ns/1ps
module cmd_source (
  input wire logic clk,
  input wire logic cmdReady,
  output logic cmdValid,
  output logic [15:0] cmdWord
);
  logic [15:0] pending [$];
  // hold a code until accepted, then send the next back to back
  always @(posedge clk)
  begin
    if (!cmdValid || cmdReady)
    begin
      #1;
      cmdValid = pending.size() > 0;
      cmdWord = cmdValid ? pending.pop_front() : ~cmdWord; // idle word keeps moving
    end
  end
  initial
  begin
    cmdValid = 1'b0;
    cmdWord = 16'h0000;
  end
endmodule : cmd_source

/* File: bench/register_read_command_decoder_props.sv */
// port checks for the register read command decoder
`timescale 1ns/1ps
module register_read_command_decoder_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  input wire logic cmdReady,
  input wire logic respValid,
  input wire logic [15:0] respWord,
  input wire logic respLast
);
  logic take;
  // an in-range code accepted at this edge
  assign take = ce && cmdValid && cmdReady && cmdWord[15:6] == 10'h003;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence answer_s;
    respValid && !respLast ##1 respValid && !respLast ##1 respValid && respLast;
  endsequence
  chk_three_words: assert property (take |-> ##2 answer_s ##1 !respValid)
    else $error("answer length wrong");
  chk_echo_code: assert property (take |-> ##2 respWord == $past(cmdWord, 2))
    else $error("echo wrong");
  chk_busy_window: assert property (take |=> !cmdReady [*3] ##1 cmdReady)
    else $error("ready window wrong");
  chk_ignore_code: assert property (ce && cmdValid && cmdReady && cmdWord[15:6] != 10'h003
    |=> cmdReady)
    else $error("foreign code taken");
  chk_rise_cause: assert property ($rose(respValid) |-> $past(take, 2))
    else $error("answer without command");
  chk_zero_upper: assert property (take && cmdWord inside {16'h00C3, 16'h00D5}
    |-> ##4 respWord == 16'h0000)
    else $error("upper word not zero");
  chk_sign_copy: assert property (take && cmdWord == 16'h00C0
    |-> ##4 respWord[15:12] == {4{respWord[11]}})
    else $error("sign bits wrong");
  chk_mag_width: assert property (take && cmdWord == 16'h00D5 |-> ##3 respWord[15:11] == 5'h00)
    else $error("magnification too wide");
endmodule : register_read_command_decoder_props

/* File: bench/register_read_command_decoder_tb.sv */
// self-checking bench for the register read command decoder
`timescale 1ns/1ps
module register_read_command_decoder_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic imgWrEn = 1'b0;
  logic [5:0] imgWrIndex = 6'h00;
  logic [31:0] imgWrData = 32'h0000_0000;
  logic cmdValid, cmdReady, respValid, respLast;
  logic [15:0] cmdWord, respWord;
  int n_errors = 0;
  int checks = 0;
  logic [15:0] codes [12] = '{16'h00C0, 16'h00C1, 16'h00C3, 16'h00C5, 16'h00C6, 16'h00C7,
    16'h00C8, 16'h00CB, 16'h00CC, 16'h00CD, 16'h00CE, 16'h00D5};
  int wid [12] = '{28, 17, 16, 32, 24, 31, 28, 28, 31, 28, 28, 11};
  logic [11:0] sgn = 12'h6D1;
  logic [31:0] vals [2] = '{32'hFFFF_FFFF, 32'h5A3C_96E1};
  register_read_command_decoder i_register_read_command_decoder (.clk(clk), .reset(reset),
    .ce(ce), .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady), .imgWrEn(imgWrEn),
    .imgWrIndex(imgWrIndex), .imgWrData(imgWrData), .respValid(respValid),
    .respWord(respWord), .respLast(respLast));
  cmd_source i_cmd_source (.clk(clk), .cmdReady(cmdReady), .cmdValid(cmdValid),
    .cmdWord(cmdWord));
  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] shape(int w, logic s, logic [31:0] v);
    logic [31:0] m;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1;
    return (v & m) | ((s && v[w-1]) ? ~m : 32'h0);
  endfunction : shape
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  // bounded wait for an answer, then a compare of each word and of its last flag
  task automatic get_resp(logic [15:0] code, logic [31:0] data);
    for (int n = 0; n < 20 && respValid !== 1'b1; n++)
      step();
    check("echo", respWord, code);
    check("last early", respLast, 1'b0);
    step();
    check("lower", respWord, data[15:0]);
    check("last early", respLast, 1'b0);
    step();
    check("upper", respWord, data[31:16]);
    check("last", respLast, 1'b1);
    // step past the upper word so the next wait cannot see this answer
    step();
    check("valid end", respValid, 1'b0);
  endtask : get_resp
  task automatic t_reset_zero;
    i_cmd_source.pending.push_back(16'h00C0);
    get_resp(16'h00C0, 32'h0000_0000);
    $display("test reset_zero done");
  endtask : t_reset_zero
  // write each item, read it back shaped to its width and sign
  task automatic t_widths;
    for (int v = 0; v < 2; v++)
      for (int i = 0; i < 12; i++)
      begin
        imgWrEn = 1'b1;
        imgWrIndex = codes[i][5:0];
        imgWrData = vals[v];
        step();
        imgWrEn = 1'b0;
        i_cmd_source.pending.push_back(codes[i]);
        get_resp(codes[i], shape(wid[i], sgn[i], vals[v]));
      end
    $display("test widths done");
  endtask : t_widths
  task automatic t_back2back;
    int k [3] = '{2, 11, 5};
    foreach (k[j]) i_cmd_source.pending.push_back(codes[k[j]]);
    foreach (k[j]) get_resp(codes[k[j]], shape(wid[k[j]], sgn[k[j]], vals[1]));
    $display("test back2back done");
  endtask : t_back2back
  task automatic t_out_of_range;
    i_cmd_source.pending.push_back(16'h00BF);
    i_cmd_source.pending.push_back(16'h00C1);
    get_resp(16'h00C1, shape(17, 1'b0, vals[1]));
    $display("test out_of_range done");
  endtask : t_out_of_range
  // a second reset in mid-run clears the stored 00C5h item again
  task automatic t_reset_again;
    reset = 1'b1;
    step();
    step();
    reset = 1'b0;
    i_cmd_source.pending.push_back(16'h00C5);
    get_resp(16'h00C5, 32'h0000_0000);
    $display("test reset_again done");
  endtask : t_reset_again
  task automatic summarize;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    t_reset_zero();
    t_widths();
    t_back2back();
    t_out_of_range();
    t_reset_again();
    summarize();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule : register_read_command_decoder_tb
bind register_read_command_decoder register_read_command_decoder_props
  i_register_read_command_decoder_props (.clk(clk), .reset(reset), .ce(ce),
  .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady), .respValid(respValid),
  .respWord(respWord), .respLast(respLast));
